//--- common/pack_pkg.sv
package pack_pkg;

  // ----------------------------------------------------------------
  // frame markers carried in the low byte of each packed word
  // ----------------------------------------------------------------
  localparam logic [7:0] MARK_W0   = 8'h00;
  localparam logic [7:0] MARK_W1   = 8'h01;
  localparam logic [7:0] MARK_W2   = 8'h02;
  localparam logic [7:0] PAD_BYTE  = 8'h00;
  localparam logic [1:0] LAST_WORD = 2'h2;

  // ----------------------------------------------------------------
  // routing source codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_PACK_PIPE = 5'h01;
  localparam logic [4:0] SRC_PACK_MIC  = 5'h02;
  localparam logic [4:0] SRC_PACK_REF  = 5'h03;
  localparam logic [4:0] SRC_PACK_ALL  = 5'h10;
  localparam logic [4:0] SRC_PACK_USB  = 5'h11;
  localparam logic [4:0] SRC_PACK_SER  = 5'h12;

  // ----------------------------------------------------------------
  // register map, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_IN_MAP  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam int          SRC_L_LSB    = 0;
  localparam int          SRC_R_LSB    = 8;
  localparam int          TWO_CH_BIT   = 16;
  localparam int          MAP_STRIDE   = 8;
  localparam int          ST_ERR_LSB   = 4;
  localparam int          ST_RES24_BIT = 8;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] MAP_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       RESP_OKAY  = 1'b0;

  // one unpacker lane: word position, held high parts, result
  typedef struct packed {
    logic [1:0]  phase;
    logic [23:0] hi0;
    logic [23:0] hi1;
    logic [31:0] s0;
    logic [31:0] s1;
    logic        mute;
    logic        done;
    logic        err;
  } unp_t;

endpackage

//--- logic/packed_audio_pack_unpack.sv
`timescale 1ns/1ns

// Summary of operation
// - each 16 kHz sample pair becomes three consecutive 48 kHz words
// - word 0: upper 24 bits of first sample, low byte 0x00
// - word 1: upper 24 bits of second sample, low byte 0x01
// - word 2: low bytes of both samples, zero byte, marker 0x02
// - one packing function serves pipeline, microphone and reference pairs
// - source 16 on both outputs emits all six channels packed
// - six-channel order: mic0, mic1, ref left, ref right, out0, out1
// - injection unpacks 48 kHz stereo into four 16 kHz pipeline inputs
// - source 17 on pipeline inputs 4..7 selects packed USB input
// - source 18 on pipeline inputs 4..7 selects packed serial input
// - frames found by markers 0x00, 0x01, 0x02 in successive low bytes
// - bad marker sequence mutes pipeline inputs fed from that stream
// - two-channel packed input feeds microphones, references get zero
// - markers occupy low audio bits; only six-channel mode loses resolution, pair words keep all 32 bits
// - packed serial audio always uses 32-bit words both ways
// - crossbar changes at run time, USB setup only at boot
module packed_audio_pack_unpack
  import pack_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              usb_res24_cfg,
  input  wire logic              cap_valid,
  input  wire logic [31:0]       cap_mic_0,
  input  wire logic [31:0]       cap_mic_1,
  input  wire logic [31:0]       cap_ref_l,
  input  wire logic [31:0]       cap_ref_r,
  input  wire logic [31:0]       cap_pipe_0,
  input  wire logic [31:0]       cap_pipe_1,
  input  wire logic              frame_tick,
  output logic [31:0]            out_word_l,
  output logic [31:0]            out_word_r,
  output logic                   out_valid,
  input  wire logic              usb_rx_valid,
  input  wire logic [31:0]       usb_rx_l,
  input  wire logic [31:0]       usb_rx_r,
  input  wire logic              ser_rx_valid,
  input  wire logic [31:0]       ser_rx_l,
  input  wire logic [31:0]       ser_rx_r,
  output logic [31:0]            pipeline_mic_in_a,
  output logic [31:0]            pipeline_mic_in_b,
  output logic [31:0]            pipeline_ref_in_left,
  output logic [31:0]            pipeline_ref_in_right,
  output logic                   pipeline_in_valid
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 4 and 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       in_map;
    logic [3:0]        err;
    logic              usb_res24;
    logic [1:0]        frame;
    logic [5:0][31:0]  cap;
    logic [5:0][31:0]  snap;
    unp_t [3:0]        unp;
    logic [31:0]       out_l;
    logic [31:0]       out_r;
    logic              out_valid;
    logic [3:0][31:0]  pin;
    logic              pin_valid;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       rdata;
    logic              ready;
    logic              resp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // shared pair packer, word index 0..2
  function automatic logic [31:0] pack_word(
    input logic [31:0] a,
    input logic [31:0] b,
    input logic [1:0]  idx
  );
    logic [31:0] w;
    w = {a[7:0], b[7:0], PAD_BYTE, MARK_W2};
    if (idx == 2'h0) begin
      w = {a[31:8], MARK_W0};
    end else if (idx == 2'h1) begin
      w = {b[31:8], MARK_W1};
    end
    return w;
  endfunction

  // pick the channel pair named by an output source
  function automatic logic [31:0] pair_word(
    input logic [4:0]       src,
    input logic [5:0][31:0] set,
    input logic [1:0]       idx
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (src)
      SRC_PACK_MIC:  w = pack_word(set[0], set[1], idx);
      SRC_PACK_REF:  w = pack_word(set[2], set[3], idx);
      SRC_PACK_PIPE: w = pack_word(set[4], set[5], idx);
      default:       w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // six-channel slot: upper 24 bits, slot number as marker;
  // the low byte of each sample is sacrificed to fit 6 into 6 slots
  function automatic logic [31:0] all_word(
    input logic [31:0] ch,
    input logic [2:0]  slot
  );
    return {ch[31:8], 5'h00, slot};
  endfunction

  // one word into an unpacker lane
  function automatic unp_t unpack_step(
    input unp_t        u,
    input logic [31:0] w
  );
    unp_t n;
    n      = u;
    n.done = 1'b0;
    n.err  = 1'b0;
    case (u.phase)
      2'h0: begin
        if (w[7:0] == MARK_W0) begin
          n.hi0   = w[31:8];
          n.phase = 2'h1;
        end else begin
          n.err = 1'b1;
        end
      end
      2'h1: begin
        if (w[7:0] == MARK_W1) begin
          n.hi1   = w[31:8];
          n.phase = LAST_WORD;
        end else begin
          n.err = 1'b1;
        end
      end
      default: begin
        if (w[7:0] == MARK_W2) begin
          n.s0    = {u.hi0, w[31:24]};
          n.s1    = {u.hi1, w[23:16]};
          n.mute  = 1'b0;
          n.done  = 1'b1;
          n.phase = 2'h0;
        end else begin
          n.err = 1'b1;
        end
      end
    endcase
    // resync: a 0x00 word restarts a group at once
    if (n.err) begin
      n.mute  = 1'b1;
      n.phase = 2'h0;
      if (w[7:0] == MARK_W0) begin
        n.hi0   = w[31:8];
        n.phase = 2'h1;
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [5:0][31:0] set;
  logic [4:0]       src_l;
  logic [4:0]       src_r;
  logic [4:0]       src_i;
  logic [3:0]       new_err;
  logic [1:0]       mute_s;
  logic [1:0]       done_s;
  logic [31:0]      rd;
  logic [ADDR_W-1:0] ra;
  logic             two_ch;

  always_comb begin
    s_d     = s_q;
    set     = s_q.snap;
    new_err = 4'h0;
    rd      = 32'h0000_0000;
    ra      = haddr[ADDR_W-1:0];
    src_l   = s_q.ctrl[SRC_L_LSB +: 5];
    src_r   = s_q.ctrl[SRC_R_LSB +: 5];
    two_ch  = s_q.ctrl[TWO_CH_BIT];
    src_i   = 5'h00;
    mute_s  = 2'h0;
    done_s  = 2'h0;
    s_d.out_valid = 1'b0;
    s_d.pin_valid = 1'b0;

    // done and err live one cycle; held over they would retrigger
    for (int k = 0; k < 4; k++) begin
      s_d.unp[k].done = 1'b0;
      s_d.unp[k].err  = 1'b0;
    end

    // latch the six monitored channels at 16 kHz
    if (cap_valid) begin
      s_d.cap = {cap_pipe_1, cap_pipe_0, cap_ref_r,
                 cap_ref_l, cap_mic_1, cap_mic_0};
    end

    // capture output, three words per 16 kHz period
    if (frame_tick) begin
      if (s_q.frame == 2'h0) begin
        set      = s_q.cap;
        s_d.snap = s_q.cap;
      end
      if (src_l == SRC_PACK_ALL && src_r == SRC_PACK_ALL) begin
        // all six channels across left and right slots
        s_d.out_l = all_word(set[{s_q.frame, 1'b0}],
                             {s_q.frame, 1'b0});
        s_d.out_r = all_word(set[{s_q.frame, 1'b1}],
                             {s_q.frame, 1'b1});
      end else begin
        s_d.out_l = pair_word(src_l, set, s_q.frame);
        s_d.out_r = pair_word(src_r, set, s_q.frame);
      end
      s_d.out_valid = 1'b1;
      s_d.frame = (s_q.frame == LAST_WORD) ? 2'h0
                                           : s_q.frame + 2'h1;
    end

    // unpacker lanes: 0/1 usb left/right, 2/3 serial left/right
    if (usb_rx_valid) begin
      s_d.unp[0] = unpack_step(s_q.unp[0], usb_rx_l);
      s_d.unp[1] = unpack_step(s_q.unp[1], usb_rx_r);
    end
    if (ser_rx_valid) begin
      s_d.unp[2] = unpack_step(s_q.unp[2], ser_rx_l);
      s_d.unp[3] = unpack_step(s_q.unp[3], ser_rx_r);
    end
    for (int k = 0; k < 4; k++) begin
      new_err[k] = s_d.unp[k].err;
    end

    // stream mute: the reference lane only counts in four-channel use;
    // a 16-bit usb link cannot carry markers, so it stays muted
    for (int b = 0; b < 2; b++) begin
      mute_s[b] = s_d.unp[2*b].mute |
                  (s_d.unp[2*b+1].mute & ~two_ch);
      done_s[b] = s_d.unp[2*b].done;
    end
    mute_s[0] = mute_s[0] | ~s_q.usb_res24;

    // crossbar for pipeline inputs 4..7, live-reconfigurable
    if (cap_valid || done_s != 2'h0) begin
      s_d.pin_valid = 1'b1;
      for (int i = 0; i < 4; i++) begin
        src_i = s_q.in_map[i*MAP_STRIDE +: 5];
        if (src_i == SRC_PACK_USB || src_i == SRC_PACK_SER) begin
          if (src_i == SRC_PACK_USB) begin
            s_d.pin[i] = i[0] ? s_d.unp[i/2].s1
                              : s_d.unp[i/2].s0;
            if (mute_s[0]) s_d.pin[i] = 32'h0000_0000;
          end else begin
            s_d.pin[i] = i[0] ? s_d.unp[2+i/2].s1
                              : s_d.unp[2+i/2].s0;
            if (mute_s[1]) s_d.pin[i] = 32'h0000_0000;
          end
          if (two_ch && i >= 2) begin
            s_d.pin[i] = 32'h0000_0000;
          end
        end else begin
          s_d.pin[i] = s_d.cap[i];
        end
      end
    end

    // bus write data phase; sticky errors, set beats clear
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == ADDR_W'(ADDR_CTRL)) begin
        s_d.ctrl = hwdata;
      end else if (s_q.wr_addr == ADDR_W'(ADDR_IN_MAP)) begin
        s_d.in_map = hwdata;
      end else if (s_q.wr_addr == ADDR_W'(ADDR_STATUS)) begin
        s_d.err = s_q.err & ~hwdata[ST_ERR_LSB +: 4];
      end
    end
    s_d.err = s_d.err | new_err;

    // bus address phase; reads see a write landing this cycle
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1] && hsize == HSIZE_WORD) begin
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = ra;
      end else begin
        if (ra == ADDR_W'(ADDR_CTRL)) begin
          rd = s_d.ctrl;
        end else if (ra == ADDR_W'(ADDR_IN_MAP)) begin
          rd = s_d.in_map;
        end else if (ra == ADDR_W'(ADDR_STATUS)) begin
          for (int k = 0; k < 4; k++) begin
            rd[k] = s_d.unp[k].mute;
          end
          rd[ST_ERR_LSB +: 4] = s_d.err;
          rd[ST_RES24_BIT]    = s_q.usb_res24;
        end
        s_d.rdata = rd;
      end
    end
    s_d.ready = 1'b1;
    s_d.resp  = RESP_OKAY;

    // synchronous reset; usb resolution fixed here only
    if (reset) begin
      s_d           = '0;
      s_d.ctrl      = CTRL_RESET;
      s_d.in_map    = MAP_RESET;
      s_d.ready     = 1'b1;
      s_d.usb_res24 = usb_res24_cfg;
      for (int k = 0; k < 4; k++) begin
        s_d.unp[k].mute = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // outputs straight from the state register
  assign hreadyout             = s_q.ready;
  assign hresp                 = s_q.resp;
  assign hrdata                = s_q.rdata;
  assign out_word_l            = s_q.out_l;
  assign out_word_r            = s_q.out_r;
  assign out_valid             = s_q.out_valid;
  assign pipeline_mic_in_a     = s_q.pin[0];
  assign pipeline_mic_in_b     = s_q.pin[1];
  assign pipeline_ref_in_left  = s_q.pin[2];
  assign pipeline_ref_in_right = s_q.pin[3];
  assign pipeline_in_valid     = s_q.pin_valid;

endmodule

//--- sim/pack_checker_props.sv
`timescale 1ns/1ns

module pack_checker
  import pack_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        frame_tick,
  input wire logic        out_valid,
  input wire logic [31:0] out_word_l,
  input wire logic        cap_valid,
  input wire logic        usb_rx_valid,
  input wire logic        ser_rx_valid,
  input wire logic        pipeline_in_valid,
  input wire logic [31:0] pipeline_mic_in_a,
  input wire logic [31:0] pipeline_ref_in_left
);
  // ----------------------------------------------------------------
  // helper: marker of the previous output word
  // ----------------------------------------------------------------
  logic [7:0] last_mark_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_mark_q <= MARK_W0;
    end else if (out_valid) begin
      last_mark_q <= out_word_l[7:0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_tick_gives_word: assert property (frame_tick |=> out_valid)
    else $error("no output word after frame tick");
  a_word_needs_tick: assert property (!frame_tick |=> !out_valid)
    else $error("output word without frame tick");
  a_words_hold: assert property (!out_valid |-> $stable(out_word_l))
    else $error("output word changed between ticks");
  a_pair_order: assert property (
    out_valid && out_word_l[7:0] == MARK_W1 |-> last_mark_q == MARK_W0)
    else $error("second word not preceded by first");
  a_cap_updates_pipe: assert property (cap_valid |=> pipeline_in_valid)
    else $error("no pipeline update after capture strobe");
  a_pipe_quiet: assert property (
    !cap_valid && !usb_rx_valid && !ser_rx_valid |=> !pipeline_in_valid)
    else $error("pipeline update without any input");
  a_pipe_hold: assert property (!pipeline_in_valid |->
    $stable(pipeline_mic_in_a) && $stable(pipeline_ref_in_left))
    else $error("pipeline input changed without update");
  a_rdata_hold: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  c_third_word: cover property (out_valid && out_word_l[7:0] == MARK_W2);
  c_usb_inject: cover property (usb_rx_valid ##1 pipeline_in_valid);
  c_ser_inject: cover property (ser_rx_valid ##1 pipeline_in_valid);
endmodule

bind packed_audio_pack_unpack pack_checker i_pack_checker (
  .core_clk, .reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .frame_tick, .out_valid, .out_word_l, .cap_valid, .usb_rx_valid,
  .ser_rx_valid, .pipeline_in_valid, .pipeline_mic_in_a,
  .pipeline_ref_in_left
);

//--- sim/host_model.sv
`timescale 1ns/1ns

module host_model (
  input  wire logic        core_clk,
  output logic             usb_rx_valid,
  output logic [31:0]      usb_rx_l,
  output logic [31:0]      usb_rx_r,
  output logic             ser_rx_valid,
  output logic [31:0]      ser_rx_l,
  output logic [31:0]      ser_rx_r
);
  logic        vld_q = 1'b0;
  logic        ser_q = 1'b0;
  logic [31:0] l_q   = 32'h0;
  logic [31:0] r_q   = 32'h0;

  // the idle stream shows inverted data so stale words never look valid
  assign usb_rx_valid = vld_q & ~ser_q;
  assign ser_rx_valid = vld_q & ser_q;
  assign usb_rx_l     = ser_q ? ~l_q : l_q;
  assign usb_rx_r     = ser_q ? ~r_q : r_q;
  assign ser_rx_l     = ser_q ? l_q : ~l_q;
  assign ser_rx_r     = ser_q ? r_q : ~r_q;

  // host carries whole 32-bit words unscaled, gain at full scale
  function automatic logic [31:0] pack_word(input logic [31:0] a, b,
                                            input int i);
    case (i)
      0: return {a[31:8], 8'h00};
      1: return {b[31:8], 8'h01};
      default: return {a[7:0], b[7:0], 8'h00, 8'h02};
    endcase
  endfunction

  // one packed group, optionally with the second marker broken
  task automatic send(input logic ser, input logic [31:0] m0, m1, f0, f1,
                      input logic bad);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      ser_q <= ser;
      vld_q <= 1'b1;
      l_q   <= (bad && i == 1) ? {m1[31:8], 8'h02} : pack_word(m0, m1, i);
      r_q   <= pack_word(f0, f1, i);
    end
    @(posedge core_clk);
    vld_q <= 1'b0;
    l_q   <= ~l_q;
    r_q   <= ~r_q;
  endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ns

module testbench
  import pack_pkg::*;
;
  logic        core_clk;
  logic        reset         = 1'b1;
  logic        hsel          = 1'b0;
  logic [31:0] haddr         = 32'h0;
  logic [1:0]  htrans        = 2'h0;
  logic        hwrite        = 1'b0;
  logic [2:0]  hsize         = HSIZE_WORD;
  logic [31:0] hwdata        = 32'h0;
  logic        usb_res24_cfg = 1'b1;
  logic        cap_valid     = 1'b0;
  logic        frame_tick    = 1'b0;
  logic [31:0] cap [6]       = '{default: 32'h0};
  logic        hreadyout, hresp, out_valid, pipeline_in_valid;
  logic        usb_rx_valid, ser_rx_valid;
  logic [31:0] hrdata, out_word_l, out_word_r, usb_rx_l, usb_rx_r;
  logic [31:0] ser_rx_l, ser_rx_r, pipeline_mic_in_a, pipeline_mic_in_b;
  logic [31:0] pipeline_ref_in_left, pipeline_ref_in_right;
  logic [4:0]  sl_tab [3]    = '{SRC_PACK_PIPE, SRC_PACK_REF, SRC_PACK_ALL};
  logic [4:0]  sr_tab [3]    = '{SRC_PACK_MIC, SRC_PACK_PIPE, SRC_PACK_ALL};
  integer      seed          = 32'he296;
  int          fails         = 0;
  int          comparisons   = 0;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  packed_audio_pack_unpack i_packed_audio_pack_unpack (
    .core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .usb_res24_cfg,
    .cap_valid, .cap_mic_0(cap[0]), .cap_mic_1(cap[1]), .cap_ref_l(cap[2]),
    .cap_ref_r(cap[3]), .cap_pipe_0(cap[4]), .cap_pipe_1(cap[5]),
    .frame_tick, .out_word_l, .out_word_r, .out_valid, .usb_rx_valid,
    .usb_rx_l, .usb_rx_r, .ser_rx_valid, .ser_rx_l, .ser_rx_r,
    .pipeline_mic_in_a, .pipeline_mic_in_b, .pipeline_ref_in_left,
    .pipeline_ref_in_right, .pipeline_in_valid
  );

  host_model i_host_model (
    .core_clk, .usb_rx_valid, .usb_rx_l, .usb_rx_r, .ser_rx_valid,
    .ser_rx_l, .ser_rx_r
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // single word transfer; waits on hready, never assumes a latency
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(rd & m, e);
  endtask

  task automatic newcap();
    @(posedge core_clk);
    foreach (cap[i]) cap[i] <= $random(seed);
    cap_valid <= 1'b1;
    @(posedge core_clk);
    cap_valid <= 1'b0;
  endtask

  function automatic logic [31:0] expw(input logic [4:0] s, input int f, d);
    case (s)
      SRC_PACK_PIPE: return i_host_model.pack_word(cap[4], cap[5], f);
      SRC_PACK_MIC:  return i_host_model.pack_word(cap[0], cap[1], f);
      SRC_PACK_REF:  return i_host_model.pack_word(cap[2], cap[3], f);
      default:       return {cap[2 * f + d][31:8], 8'(2 * f + d)};
    endcase
  endfunction

  task automatic tick3(input logic [4:0] sl, sr);
    for (int f = 0; f < 3; f++) begin
      @(posedge core_clk);
      frame_tick <= 1'b1;
      @(posedge core_clk);
      frame_tick <= 1'b0;
      #1;
      check(out_word_l, expw(sl, f, 0));
      check(out_word_r, expw(sr, f, 1));
    end
  endtask

  // mode 0 good, 1 broken markers, 2 two-channel, 3 stream kept muted
  task automatic inject(input logic ser, input int mode);
    logic [31:0] s [4];
    logic [31:0] e [4];
    foreach (s[i]) s[i] = $random(seed);
    i_host_model.send(ser, s[0], s[1], s[2], s[3], mode == 1);
    if (mode == 1) newcap();
    foreach (e[i]) e[i] = (mode[0] || (mode == 2 && i > 1)) ? 32'h0 : s[i];
    #1;
    if (mode[0] == 1'b0) check({31'h0, pipeline_in_valid}, 32'h1);
    check(pipeline_mic_in_a, e[0]);
    check(pipeline_mic_in_b, e[1]);
    check(pipeline_ref_in_left, e[2]);
    check(pipeline_ref_in_right, e[3]);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(ADDR_CTRL, 32'hffff_ffff, CTRL_RESET);
    rdchk(ADDR_IN_MAP, 32'hffff_ffff, MAP_RESET);
    rdchk(8'h0c, 32'hffff_ffff, 32'h0);
    rdchk(ADDR_STATUS, 32'h1ff, 32'h10f);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, {19'h0, sr_tab[k], 3'h0, sl_tab[k]});
      rdchk(ADDR_CTRL, 32'h1_1f1f, {19'h0, sr_tab[k], 3'h0, sl_tab[k]});
      newcap();
      #1;
      check(pipeline_mic_in_a, cap[0]);
      check(pipeline_ref_in_right, cap[3]);
      tick3(sl_tab[k], sr_tab[k]);
    end
    wr(ADDR_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      // source 17 for usb, 18 for serial on inputs 4 to 7
      wr(ADDR_IN_MAP, k ? 32'h1212_1212 : 32'h1111_1111);
      inject(k[0], 0);
      inject(k[0], 1);
      rdchk(ADDR_STATUS, 32'h10 << 2 * k, 32'h10 << 2 * k);
      inject(k[0], 0);
      wr(ADDR_STATUS, 32'hf0);
      rdchk(ADDR_STATUS, 32'hf0, 32'h0);
    end
    wr(ADDR_CTRL, 32'h1_0000);
    inject(1'b1, 2);
    // second reset with a 16-bit usb link: usb stream stays muted
    @(posedge core_clk);
    reset         <= 1'b1;
    usb_res24_cfg <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(ADDR_STATUS, 32'h100, 32'h0);
    wr(ADDR_IN_MAP, 32'h1111_1111);
    inject(1'b0, 3);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
endmodule
